// >>> rtl/fls_pkg.sv
// Shared constants for the fault limit supervisor
package fls_pkg;

    // Command codes, one per register
    localparam logic [7:0] CMD_UV_LIMIT     = 8'h44;
    localparam logic [7:0] CMD_UV_ACTION    = 8'h45;
    localparam logic [7:0] CMD_OC_LIMIT     = 8'h46;
    localparam logic [7:0] CMD_OC_WARN      = 8'h4a;
    localparam logic [7:0] CMD_UC_LIMIT     = 8'h4b;
    localparam logic [7:0] CMD_OT_LIMIT     = 8'h4f;
    localparam logic [7:0] CMD_OT_ACTION    = 8'h50;
    localparam logic [7:0] CMD_OT_WARN      = 8'h51;
    localparam logic [7:0] CMD_UT_WARN      = 8'h52;
    localparam logic [7:0] CMD_UT_LIMIT     = 8'h53;
    localparam logic [7:0] CMD_UT_ACTION    = 8'h54;

    // Values after reset
    localparam logic [7:0]  ACTION_RESET    = 8'h80;
    localparam logic [15:0] OC_LIMIT_RESET  = 16'he320;
    localparam logic [15:0] UC_LIMIT_RESET  = 16'he4e0;
    localparam logic [15:0] OT_LIMIT_RESET  = 16'heb98;
    localparam logic [15:0] OT_WARN_RESET   = 16'heb48;
    localparam logic [15:0] UT_WARN_RESET   = 16'hdc40;
    localparam logic [15:0] UT_LIMIT_RESET  = 16'he530;

    // Hard bounds on the current limits, +50 A and -50 A
    localparam logic [15:0] PEAK_LIMIT_MAX  = 16'he320;
    localparam logic [15:0] VALLEY_LIMIT_MIN = 16'he4e0;

    // Response byte layout
    localparam int          ACT_RSVD_HI     = 7;
    localparam int          ACT_RSVD_LO     = 6;
    localparam logic [1:0]  ACT_RSVD_VALUE  = 2'b10;
    localparam int          ACT_RETRY_HI    = 5;
    localparam int          ACT_RETRY_LO    = 3;
    localparam int          ACT_DELAY_HI    = 2;
    localparam int          ACT_DELAY_LO    = 0;
    localparam logic [2:0]  RETRY_NONE      = 3'b000;
    localparam logic [2:0]  RETRY_FOREVER   = 3'b111;

    // Status flag positions
    localparam int ST_UV      = 0;
    localparam int ST_OC      = 1;
    localparam int ST_UC      = 2;
    localparam int ST_OT      = 3;
    localparam int ST_UT      = 4;
    localparam int ST_OT_WARN = 5;
    localparam int ST_UT_WARN = 6;
    localparam int ST_TEMP    = 7;

    // Timing
    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned RETRY_STEP_MS     = 35;
    localparam int unsigned RETRY_STEP_CYCLES =
        RETRY_STEP_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        RUN_OFF   = 2'b00,
        RUN_ON    = 2'b01,
        RUN_LATCH = 2'b10,
        RUN_WAIT  = 2'b11
    } fls_run_state_type;

endpackage

// >>> rtl/fls_retry_timer.sv
// Shutdown and restart sequencer for one output channel
`timescale 1ns/1ps
`default_nettype none

module fls_retry_timer #(
    parameter int unsigned STEP_CYCLES = fls_pkg::RETRY_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Requests
    input  wire logic       run_req,
    input  wire logic       trip_latch,
    input  wire logic       trip_retry,
    input  wire logic [2:0] retry_delay,
    input  wire logic       clear,
    // Result
    output logic            out_on,
    output logic            retrying
);

    fls_pkg::fls_run_state_type state_reg;
    logic [31:0]                wait_cnt_reg;
    logic [31:0]                wait_load;

    // Whole wait is (delay + 1) steps, counted down to zero
    assign wait_load = 32'((32'(retry_delay) + 32'd1) * STEP_CYCLES) - 32'd1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= fls_pkg::RUN_OFF;
            wait_cnt_reg <= 32'h0000_0000;
        end else if (ce) begin
            unique case (state_reg)
                fls_pkg::RUN_OFF: begin
                    if (run_req) begin
                        state_reg <= fls_pkg::RUN_ON;
                    end
                end
                fls_pkg::RUN_ON: begin
                    if (!run_req) begin
                        state_reg <= fls_pkg::RUN_OFF;
                    end else if (trip_latch) begin
                        state_reg <= fls_pkg::RUN_LATCH;
                    end else if (trip_retry) begin
                        state_reg    <= fls_pkg::RUN_WAIT;
                        wait_cnt_reg <= wait_load;
                    end
                end
                fls_pkg::RUN_LATCH: begin
                    // Stays off, even when disabled, until cleared
                    if (clear) begin
                        state_reg <= fls_pkg::RUN_OFF;
                    end
                end
                fls_pkg::RUN_WAIT: begin
                    if (!run_req) begin
                        state_reg <= fls_pkg::RUN_OFF;
                    end else if (trip_latch) begin
                        state_reg <= fls_pkg::RUN_LATCH;
                    end else if (wait_cnt_reg == 32'h0000_0000) begin
                        // Restart without looking at the fault
                        state_reg <= fls_pkg::RUN_ON;
                    end else begin
                        wait_cnt_reg <= wait_cnt_reg - 32'd1;
                    end
                end
            endcase
        end
    end

    assign out_on   = (state_reg == fls_pkg::RUN_ON);
    assign retrying = (state_reg == fls_pkg::RUN_WAIT);

endmodule // fls_retry_timer

`default_nettype wire

// >>> rtl/fls_fault_supervisor.sv
// Two-channel fault limit supervisor with command register file
`timescale 1ns/1ps
`default_nettype none

module fls_fault_supervisor #(
    parameter int unsigned RETRY_STEP_CYCLES = fls_pkg::RETRY_STEP_CYCLES,
    parameter logic [15:0] UV_LIMIT_STRAP    = 16'h0000,
    parameter logic [15:0] OC_WARN_STRAP     = 16'h0000
) (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    // Command port
    input  wire logic             cmd_wr,
    input  wire logic             cmd_rd,
    input  wire logic             cmd_page,
    input  wire logic [7:0]       cmd_code,
    input  wire logic             cmd_word,
    input  wire logic [15:0]      cmd_wdata,
    output logic                  rd_valid,
    output logic                  rd_word,
    output logic [15:0]           rd_data,
    output logic                  cmd_err,
    // Channel control and telemetry
    input  wire logic [1:0]       rail_en,
    input  wire logic [1:0]       ramping,
    input  wire logic [1:0]       clear_fault,
    input  wire logic [1:0][15:0] vout,
    input  wire logic [1:0][15:0] iout,
    input  wire logic [1:0]       iout_valid,
    input  wire logic [1:0]       blank_done,
    input  wire logic [1:0][15:0] temp,
    input  wire logic [1:0]       avg_oc_fault,
    input  wire logic [1:0]       avg_uc_fault,
    input  wire logic [1:0][7:0]  avg_oc_action,
    input  wire logic [1:0][7:0]  avg_uc_action,
    // Channel results
    output logic [1:0]            out_on,
    output logic [1:0]            retrying,
    output logic [1:0][7:0]       status,
    output logic                  alert
);

    logic        rst_meta_reg;
    logic        rst_n_reg;
    logic [15:0] uv_lim_reg  [2];
    logic [7:0]  uv_act_reg  [2];
    logic [15:0] oc_lim_reg  [2];
    logic [15:0] oc_warn_reg [2];
    logic [15:0] uc_lim_reg  [2];
    logic [15:0] ot_lim_reg  [2];
    logic [7:0]  ot_act_reg  [2];
    logic [15:0] ot_warn_reg [2];
    logic [15:0] ut_warn_reg [2];
    logic [15:0] ut_lim_reg  [2];
    logic [7:0]  ut_act_reg  [2];
    logic [1:0]  ot_active_reg;
    logic [1:0]  ut_active_reg;
    logic [1:0]  ot_active_next;
    logic [1:0]  ut_active_next;
    logic [1:0][7:0] status_reg;
    logic [1:0][7:0] status_set;
    logic [1:0]  trip_latch;
    logic [1:0]  trip_retry;
    logic [1:0][2:0] trip_delay;
    logic        code_known;
    logic        code_is_byte;
    logic        cmd_ok;

    // Reset released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Linear value of a mantissa/exponent word, 16 fraction bits
    function automatic logic signed [63:0] lin(input logic [15:0] w);
        logic signed [63:0] m;
        logic [4:0]         sh;
        m   = {{53{w[10]}}, w[10:0]};
        sh  = {~w[15], w[14:11]};
        lin = m <<< sh;
    endfunction

    function automatic logic is_forever(input logic [7:0] a);
        is_forever = (a[fls_pkg::ACT_RETRY_HI:fls_pkg::ACT_RETRY_LO]
                      == fls_pkg::RETRY_FOREVER);
    endfunction

    function automatic logic [7:0] fix_action(input logic [7:0] a);
        fix_action = {fls_pkg::ACT_RSVD_VALUE, a[5:0]};
    endfunction

    // Command length check and decode
    always_comb begin
        code_known   = 1'b1;
        code_is_byte = 1'b0;
        unique case (cmd_code)
            fls_pkg::CMD_UV_ACTION,
            fls_pkg::CMD_OT_ACTION,
            fls_pkg::CMD_UT_ACTION: code_is_byte = 1'b1;
            fls_pkg::CMD_UV_LIMIT,
            fls_pkg::CMD_OC_LIMIT,
            fls_pkg::CMD_OC_WARN,
            fls_pkg::CMD_UC_LIMIT,
            fls_pkg::CMD_OT_LIMIT,
            fls_pkg::CMD_OT_WARN,
            fls_pkg::CMD_UT_WARN,
            fls_pkg::CMD_UT_LIMIT:  code_is_byte = 1'b0;
            default:                code_known   = 1'b0;
        endcase
        cmd_ok = code_known && (cmd_word == !code_is_byte);
    end

    // Register writes, one set per page
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            for (int c = 0; c < 2; c++) begin
                uv_lim_reg[c]  <= UV_LIMIT_STRAP;
                uv_act_reg[c]  <= fls_pkg::ACTION_RESET;
                oc_lim_reg[c]  <= fls_pkg::OC_LIMIT_RESET;
                oc_warn_reg[c] <= OC_WARN_STRAP;
                uc_lim_reg[c]  <= fls_pkg::UC_LIMIT_RESET;
                ot_lim_reg[c]  <= fls_pkg::OT_LIMIT_RESET;
                ot_act_reg[c]  <= fls_pkg::ACTION_RESET;
                ot_warn_reg[c] <= fls_pkg::OT_WARN_RESET;
                ut_warn_reg[c] <= fls_pkg::UT_WARN_RESET;
                ut_lim_reg[c]  <= fls_pkg::UT_LIMIT_RESET;
                ut_act_reg[c]  <= fls_pkg::ACTION_RESET;
            end
        end else if (ce && cmd_wr && cmd_ok) begin
            unique case (cmd_code)
                fls_pkg::CMD_UV_LIMIT:
                    uv_lim_reg[cmd_page] <= cmd_wdata;
                fls_pkg::CMD_UV_ACTION:
                    uv_act_reg[cmd_page] <= fix_action(cmd_wdata[7:0]);
                fls_pkg::CMD_OC_LIMIT:
                    oc_lim_reg[cmd_page] <=
                        (lin(cmd_wdata) > lin(fls_pkg::PEAK_LIMIT_MAX))
                        ? fls_pkg::PEAK_LIMIT_MAX : cmd_wdata;
                fls_pkg::CMD_OC_WARN:
                    oc_warn_reg[cmd_page] <= cmd_wdata;
                fls_pkg::CMD_UC_LIMIT:
                    uc_lim_reg[cmd_page] <=
                        (lin(cmd_wdata) < lin(fls_pkg::VALLEY_LIMIT_MIN))
                        ? fls_pkg::VALLEY_LIMIT_MIN : cmd_wdata;
                fls_pkg::CMD_OT_LIMIT:
                    ot_lim_reg[cmd_page] <= cmd_wdata;
                fls_pkg::CMD_OT_ACTION:
                    ot_act_reg[cmd_page] <= fix_action(cmd_wdata[7:0]);
                fls_pkg::CMD_OT_WARN:
                    ot_warn_reg[cmd_page] <= cmd_wdata;
                fls_pkg::CMD_UT_WARN:
                    ut_warn_reg[cmd_page] <= cmd_wdata;
                fls_pkg::CMD_UT_LIMIT:
                    ut_lim_reg[cmd_page] <= cmd_wdata;
                fls_pkg::CMD_UT_ACTION:
                    ut_act_reg[cmd_page] <= fix_action(cmd_wdata[7:0]);
                default: ;
            endcase
        end
    end

    // Read answers and command errors
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rd_valid <= 1'b0;
            rd_word  <= 1'b0;
            rd_data  <= 16'h0000;
            cmd_err  <= 1'b0;
        end else if (ce) begin
            rd_valid <= cmd_rd && cmd_ok;
            cmd_err  <= (cmd_rd || cmd_wr) && !cmd_ok;
            if (cmd_rd && cmd_ok) begin
                rd_word <= !code_is_byte;
                unique case (cmd_code)
                    fls_pkg::CMD_UV_LIMIT:  rd_data <= uv_lim_reg[cmd_page];
                    fls_pkg::CMD_UV_ACTION: rd_data <= {8'h00, uv_act_reg[cmd_page]};
                    fls_pkg::CMD_OC_LIMIT:  rd_data <= oc_lim_reg[cmd_page];
                    fls_pkg::CMD_OC_WARN:   rd_data <= oc_warn_reg[cmd_page];
                    fls_pkg::CMD_UC_LIMIT:  rd_data <= uc_lim_reg[cmd_page];
                    fls_pkg::CMD_OT_LIMIT:  rd_data <= ot_lim_reg[cmd_page];
                    fls_pkg::CMD_OT_ACTION: rd_data <= {8'h00, ot_act_reg[cmd_page]};
                    fls_pkg::CMD_OT_WARN:   rd_data <= ot_warn_reg[cmd_page];
                    fls_pkg::CMD_UT_WARN:   rd_data <= ut_warn_reg[cmd_page];
                    fls_pkg::CMD_UT_LIMIT:  rd_data <= ut_lim_reg[cmd_page];
                    fls_pkg::CMD_UT_ACTION: rd_data <= {8'h00, ut_act_reg[cmd_page]};
                    default:                rd_data <= 16'h0000;
                endcase
            end
        end
    end

    // Fault detection and response selection per channel
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            logic uv_t;
            logic oc_t;
            logic uc_t;
            logic ot_t;
            logic ut_t;
            logic qual;
            logic signed [63:0] t;
            uv_t = 1'b0;
            oc_t = 1'b0;
            uc_t = 1'b0;
            ot_t = 1'b0;
            ut_t = 1'b0;
            t    = lin(temp[c]);
            qual = iout_valid[c] && blank_done[c];
            status_set[c] = 8'h00;
            uv_t = rail_en[c] && !ramping[c] && out_on[c]
                   && (vout[c] < uv_lim_reg[c]);
            oc_t = (qual && (lin(iout[c]) > lin(oc_lim_reg[c])))
                   || avg_oc_fault[c];
            uc_t = (qual && (lin(iout[c]) < lin(uc_lim_reg[c])))
                   || avg_uc_fault[c];
            // Hysteresis: warning limit releases the held fault
            ot_active_next[c] = ot_active_reg[c]
                ? !(t < lin(ot_warn_reg[c]))
                : (t > lin(ot_lim_reg[c]));
            ut_active_next[c] = ut_active_reg[c]
                ? !(t > lin(ut_warn_reg[c]))
                : (t < lin(ut_lim_reg[c]));
            ot_t = ot_active_next[c] && !ot_active_reg[c];
            ut_t = ut_active_next[c] && !ut_active_reg[c];
            status_set[c][fls_pkg::ST_UV] = uv_t;
            status_set[c][fls_pkg::ST_OC] = oc_t;
            status_set[c][fls_pkg::ST_UC] = uc_t;
            status_set[c][fls_pkg::ST_OT] = ot_active_next[c];
            status_set[c][fls_pkg::ST_UT] = ut_active_next[c];
            status_set[c][fls_pkg::ST_OT_WARN] =
                t > lin(ot_warn_reg[c]);
            status_set[c][fls_pkg::ST_UT_WARN] =
                t < lin(ut_warn_reg[c]);
            status_set[c][fls_pkg::ST_TEMP] =
                status_set[c][fls_pkg::ST_OT_WARN]
                || status_set[c][fls_pkg::ST_UT_WARN]
                || ot_active_next[c] || ut_active_next[c];
            // Only a running output can trip; lowest priority first
            oc_t = oc_t && out_on[c];
            uc_t = uc_t && out_on[c];
            ot_t = ot_t && out_on[c];
            ut_t = ut_t && out_on[c];
            trip_latch[c] = (uv_t && !is_forever(uv_act_reg[c]))
                || (oc_t && !is_forever(avg_oc_action[c]))
                || (uc_t && !is_forever(avg_uc_action[c]))
                || (ot_t && !is_forever(ot_act_reg[c]))
                || (ut_t && !is_forever(ut_act_reg[c]));
            trip_retry[c] = uv_t || oc_t || uc_t || ot_t || ut_t;
            trip_delay[c] = 3'b000;
            if (ut_t) begin
                trip_delay[c] = ut_act_reg[c][2:0];
            end
            if (ot_t) begin
                trip_delay[c] = ot_act_reg[c][2:0];
            end
            if (uc_t) begin
                trip_delay[c] = avg_uc_action[c][2:0];
            end
            if (oc_t) begin
                trip_delay[c] = avg_oc_action[c][2:0];
            end
            if (uv_t) begin
                trip_delay[c] = uv_act_reg[c][2:0];
            end
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            status_reg    <= '0;
            ot_active_reg <= 2'b00;
            ut_active_reg <= 2'b00;
        end else if (ce) begin
            ot_active_reg <= ot_active_next;
            ut_active_reg <= ut_active_next;
            for (int c = 0; c < 2; c++) begin
                status_reg[c] <= (status_reg[c] & ~{8{clear_fault[c]}})
                                 | status_set[c];
            end
        end
    end

    assign status = status_reg;
    assign alert  = |status_reg;

    // One restart sequencer per channel
    for (genvar g = 0; g < 2; g++) begin : g_chan
        fls_retry_timer #(
            .STEP_CYCLES (RETRY_STEP_CYCLES)
        ) u_retry (
            .clk         (clk),
            .rst_n       (rst_n_reg),
            .ce          (ce),
            .run_req     (rail_en[g]),
            .trip_latch  (trip_latch[g]),
            .trip_retry  (trip_retry[g]),
            .retry_delay (trip_delay[g]),
            .clear       (clear_fault[g]),
            .out_on      (out_on[g]),
            .retrying    (retrying[g])
        );
    end

endmodule // fls_fault_supervisor

`default_nettype wire

// >>> test/fls_properties.sv
// Port-level assertions for the fault limit supervisor
`timescale 1ns/1ps
`default_nettype none
module fls_properties #(
    parameter int unsigned RETRY_STEP_CYCLES = 4
) (
    // Design inputs
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic            cmd_wr,
    input wire logic            cmd_rd,
    input wire logic [1:0]      rail_en,
    input wire logic [1:0]      ramping,
    // Design outputs
    input wire logic            rd_valid,
    input wire logic            rd_word,
    input wire logic [15:0]     rd_data,
    input wire logic            cmd_err,
    input wire logic [1:0]      out_on,
    input wire logic [1:0]      retrying,
    input wire logic [1:0][7:0] status,
    input wire logic            alert
);
    int unsigned wait_cnt;

    // Length of the running restart wait on channel 0
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) wait_cnt <= 0;
        else wait_cnt <= retrying[0] ? wait_cnt + 1 : 0;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_rd_answer: assert property (cmd_rd |=> rd_valid ^ cmd_err)
        else $error("read request got no single answer");
    chk_rd_cause: assert property (rd_valid |-> $past(cmd_rd))
        else $error("read answer without request");
    chk_err_cause: assert property (cmd_err |-> $past(cmd_wr || cmd_rd))
        else $error("error pulse without request");
    chk_rsvd_bits:
        assert property (rd_valid && !rd_word |-> rd_data[15:6] == 10'h002)
        else $error("action byte lost its fixed pattern");
    chk_uv_mask:
        assert property (!rail_en[0] || ramping[0] |=>
            !$rose(status[0][fls_pkg::ST_UV]))
        else $error("undervoltage flagged while masked");
    chk_alert_or: assert property (alert == |status)
        else $error("alert does not follow status");
    chk_temp_sum:
        assert property (status[1][fls_pkg::ST_OT_WARN] ||
            status[1][fls_pkg::ST_UT_WARN] |-> status[1][fls_pkg::ST_TEMP])
        else $error("temperature summary missing");
    chk_retry_span:
        assert property ($fell(retrying[0]) && out_on[0] |->
            wait_cnt % RETRY_STEP_CYCLES == 0 && wait_cnt != 0 &&
            wait_cnt <= 8 * RETRY_STEP_CYCLES)
        else $error("restart wait is not a whole number of steps");

    cover property ($rose(retrying[0]));
    cover property ($fell(out_on[1]) && !retrying[1]);
    cover property (cmd_err);
endmodule // fls_properties

bind fls_fault_supervisor fls_properties #(
    .RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)
) u_props (
    .clk(clk), .resetn(resetn), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .rail_en(rail_en), .ramping(ramping), .rd_valid(rd_valid),
    .rd_word(rd_word), .rd_data(rd_data), .cmd_err(cmd_err),
    .out_on(out_on), .retrying(retrying), .status(status), .alert(alert)
);
`default_nettype wire

// >>> test/fls_host_model.sv
// Host model that issues register commands to the supervisor
`timescale 1ns/1ps
`default_nettype none
module fls_host_model (
    // Clock
    input  wire logic        clk,
    // Command request
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic             cmd_page,
    output logic [7:0]       cmd_code,
    output logic             cmd_word,
    output logic [15:0]      cmd_wdata,
    // Answer
    input  wire logic        rd_valid,
    input  wire logic        rd_word,
    input  wire logic [15:0] rd_data,
    input  wire logic        cmd_err
);
    initial begin
        {cmd_wr, cmd_rd, cmd_page, cmd_word} = 4'h0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // One request cycle; answer taken half a cycle after the take edge
    task automatic xfer(input logic wr, input logic pg, input logic [7:0] c,
        input logic wd, input logic [15:0] d, input logic raw,
        output logic [15:0] q, output logic v, output logic e,
        output logic rw);
        @(negedge clk);
        cmd_wr = wr;
        cmd_rd = !wr;
        cmd_page = pg;
        cmd_code = c;
        cmd_word = wd;
        cmd_wdata = (wd || raw) ? d : {8'h00, 2'b10, d[5:0]};
        @(negedge clk);
        {cmd_wr, cmd_rd} = 2'b00;
        // Idle data inverted so a stale word cannot pass for fresh
        cmd_wdata = ~cmd_wdata;
        {q, v, e, rw} = {rd_data, rd_valid, cmd_err, rd_word};
    endtask
endmodule // fls_host_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the fault limit supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Small step keeps the restart wait short
    localparam int unsigned STEP = 4;
    // Row: code, word, write, write data, expected read
    localparam logic [41:0] ROWS [17] = '{
        {8'h44,2'b10,16'h0000,16'h0000}, {8'h45,2'b00,16'h0000,16'h0080},
        {8'h46,2'b10,16'h0000,16'he320}, {8'h4a,2'b10,16'h0000,16'h0000},
        {8'h4b,2'b10,16'h0000,16'he4e0}, {8'h4f,2'b10,16'h0000,16'heb98},
        {8'h50,2'b00,16'h0000,16'h0080}, {8'h51,2'b10,16'h0000,16'heb48},
        {8'h52,2'b10,16'h0000,16'hdc40}, {8'h53,2'b10,16'h0000,16'he530},
        {8'h54,2'b00,16'h0000,16'h0080},
        {8'h46,2'b11,16'he340,16'he320},
        {8'h46,2'b11,16'he300,16'he300},
        {8'h4b,2'b11,16'he4c0,16'he4e0},
        {8'h4b,2'b11,16'he500,16'he500},
        {8'h45,2'b01,16'h003f,16'h00bf},
        {8'h44,2'b11,16'h1234,16'h1234}};
    logic             clk, resetn, ce, cmd_wr, cmd_rd, cmd_page, cmd_word;
    logic             rd_valid, rd_word, cmd_err, alert, v, e, w;
    logic [7:0]       cmd_code;
    logic [15:0]      cmd_wdata, rd_data, q;
    logic [41:0]      r;
    logic [1:0]       rail_en, ramping, clear_fault, iout_valid, blank_done;
    logic [1:0]       avg_oc_fault, avg_uc_fault, out_on, retrying;
    logic [1:0][15:0] vout, iout, temp;
    logic [1:0][7:0]  avg_oc_action, avg_uc_action, status;
    int               errors, checked, n;

    fls_host_model host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_word(cmd_word),
        .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_word(rd_word),
        .rd_data(rd_data), .cmd_err(cmd_err));
    fls_fault_supervisor #(.RETRY_STEP_CYCLES(STEP)) uut (.clk(clk),
        .resetn(resetn), .ce(ce), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_word(cmd_word),
        .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_word(rd_word),
        .rd_data(rd_data), .cmd_err(cmd_err), .rail_en(rail_en),
        .ramping(ramping), .clear_fault(clear_fault), .vout(vout),
        .iout(iout), .iout_valid(iout_valid), .blank_done(blank_done),
        .temp(temp), .avg_oc_fault(avg_oc_fault),
        .avg_uc_fault(avg_uc_fault), .avg_oc_action(avg_oc_action),
        .avg_uc_action(avg_uc_action), .out_on(out_on),
        .retrying(retrying), .status(status), .alert(alert));

    task automatic chk(input logic [17:0] got, input logic [17:0] exp,
        input string m);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic rd(input logic pg, input logic [7:0] c, input logic wd);
        host.xfer(1'b0, pg, c, wd, 16'h0000, 1'b0, q, v, e, w);
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic clr;
        clear_fault[1] = 1'b1;
        tick(1);
        clear_fault[1] = 1'b0;
        tick(1);
    endtask
    task automatic summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize();
    end
    initial begin
        {errors, checked} = '0;
        {resetn, clear_fault, iout_valid, blank_done} = 7'h00;
        {avg_oc_fault, avg_uc_fault, vout, iout} = '0;
        {ce, rail_en, ramping} = 5'h1f;
        temp = {2{16'h0019}};
        avg_oc_action = {2{8'h80}};
        avg_uc_action = {2{8'h80}};
        tick(6);
        resetn = 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 34; i++) begin
            r = ROWS[i % 17];
            if (r[32])
                host.xfer(1'b1, i > 16, r[41:34], r[33], r[31:16], 1'b1,
                    q, v, e, w);
            rd(i > 16, r[41:34], r[33]);
            chk({w, v, q}, {r[33], 1'b1, r[15:0]}, "row");
        end
        host.xfer(1'b1, 1'b0, 8'h45, 1'b1, 16'h0081, 1'b1, q, v, e, w);
        chk({v, e}, 2'b01, "length refused");
        rd(1'b0, 8'h47, 1'b0);
        chk({v, e}, 2'b01, "unknown code");
        rd(1'b0, 8'h45, 1'b0);
        chk(q, 16'h00bf, "refused write kept out");
        chk(status[0], 8'h00, "uv masked in ramp");
        ramping[0] = 1'b0;
        tick(1);
        chk({out_on[0], retrying[0], status[0]}, 10'h101, "uv trip");
        n = 0;
        while (retrying[0] && n < 1000) begin
            tick(1);
            n++;
        end
        chk(18'(n), 18'(8 * STEP), "retry wait");
        chk(out_on[0], 1'b1, "restart with fault");
        rail_en[0] = 1'b0;
        temp[1] = 16'h0078;
        tick(3);
        chk({out_on[1], retrying[1], status[1]}, 10'h0a8, "ot");
        temp[1] = 16'h006e;
        clr();
        chk(status[1], 8'ha8, "ot held");
        temp[1] = 16'h0019;
        clr();
        chk({out_on[1], status[1]}, 9'h100, "ot cleared");
        {iout[1], iout_valid[1]} = {16'h0032, 1'b1};
        tick(2);
        chk({out_on[1], status[1]}, 9'h100, "blanked sample");
        blank_done[1] = 1'b1;
        tick(1);
        chk({out_on[1], status[1]}, 9'h002, "peak oc");
        iout[1] = 16'he4e0;
        tick(1);
        chk(status[1], 8'h06, "valley uc");
        iout_valid[1] = 1'b0;
        clr();
        {avg_oc_fault[1], avg_uc_fault[1]} = 2'b11;
        tick(1);
        {avg_oc_fault[1], avg_uc_fault[1]} = 2'b00;
        chk(status[1], 8'h06, "average faults");
        temp[1] = 16'he4e0;
        tick(1);
        temp[1] = 16'he580;
        clr();
        chk(status[1], 8'hd0, "ut held");
        resetn = 1'b0;
        tick(1);
        chk({alert, status}, 17'h0, "reset clears");
        tick(5);
        resetn = 1'b1;
        repeat (3) @(posedge clk);
        rd(1'b1, 8'h46, 1'b1);
        chk(q, 16'he320, "limit default again");
        summarize();
    end
endmodule // tb
`default_nettype wire
